// ---- adcgc_fifo.sv ----
`timescale 1ns/1ps
module adcgc_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    adcgc_stream_if.snk in_s,
    adcgc_stream_if.src out_s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
    logic [AW:0] count_q, count_d;
    logic [W-1:0] dout_q, dout_d;
    logic ov_q, ov_d;
    logic push, pop;

    assign in_s.ready = (count_q != DEPTH[AW:0]);
    assign out_s.data = dout_q;
    assign out_s.valid = ov_q;

    always_comb
    begin
        push = in_s.valid && in_s.ready;
        // The output stage refills whenever it is empty or being taken.
        pop = (count_q != '0) && (!ov_q || out_s.ready);
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d = count_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        dout_d = pop ? mem[rd_ptr_q] : dout_q;
        ov_d = pop ? 1'b1 : (out_s.ready ? 1'b0 : ov_q);
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= in_s.data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
            dout_q <= '0;
            ov_q <= 1'b0;
        end
        else
        begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q <= count_d;
            dout_q <= dout_d;
            ov_q <= ov_d;
        end
    end
endmodule : adcgc_fifo

// ---- adcgc_front_model.sv ----
`timescale 1ns/1ps
module adcgc_front_model
    import adcgc_pkg::*;
#(
    parameter int HALF = 2
) (
    input wire logic ref_clk,
    input wire logic polarity_swap,
    input wire logic [ADCGC_RES_W-1:0] sig,
    input wire logic [ADCGC_RES_W-1:0] ofs,
    output logic adc_clk_pin,
    output logic [ADCGC_RES_W-1:0] mod_result
);
    int ph = 0;
    logic aclk_q = 1'b0;
    assign adc_clk_pin = aclk_q;
    always @(posedge ref_clk)
    begin
        ph <= (ph == HALF - 1) ? 0 : ph + 1;
        if (ph == HALF - 1)
            aclk_q <= ~aclk_q;
    end
    // Swapped inputs negate the signal but keep the offset, so only the halved difference cancels it.
    assign mod_result = polarity_swap ? ofs - sig : ofs + sig;
endmodule : adcgc_front_model

// ---- adcgc_pkg.sv ----
package adcgc_pkg;

    localparam logic [7:0] ADCGC_DRATE_ADDR = 8'h04;
    localparam logic [7:0] ADCGC_DRATE_RESET = 8'h14;
    localparam int ADCGC_DR_LSB = 0;
    localparam int ADCGC_DR_W = 4;
    localparam int ADCGC_LOWLAT_BIT = 4;
    localparam int ADCGC_SINGLE_BIT = 5;
    localparam int ADCGC_CHOP_BIT = 7;

    localparam int ADCGC_RES_W = 24;
    localparam int ADCGC_CNT_W = 20;
    localparam int ADCGC_FIFO_DEPTH = 16;

    // Last count of the ADC clock divider; one modulator_period is sixteen ADC clock cycles.
    localparam logic [3:0] ADCGC_MOD_DIV_LAST = 4'hf;
    // Default pre-conversion delay, in modulator periods, before each conversion of a pair.
    localparam logic [ADCGC_CNT_W-1:0] ADCGC_DELAY_MODULATOR_PERIOD = 20'h0000e;

    typedef enum logic [1:0] {
        ADCGC_IDLE = 2'b00,
        ADCGC_DELAY = 2'b01,
        ADCGC_CONV = 2'b11
    } adcgc_state_t;

    // Length of one settled conversion, in modulator periods, per filter and data rate.
    function automatic logic [ADCGC_CNT_W-1:0] adcgc_conv_len(input logic lowlat,
                                                              input logic [3:0] dr);
        logic [ADCGC_CNT_W-1:0] v;
        v = 20'h00000;
        if (lowlat)
        begin
            case (dr)
                4'h0: v = 20'd104065;
                4'h1: v = 20'd52865;
                4'h2: v = 20'd27265;
                4'h3: v = 20'd15425;
                4'h4: v = 20'd14465;
                4'h5: v = 20'd5160;
                4'h6: v = 20'd4329;
                4'h7: v = 20'd2600;
                4'h8: v = 20'd1320;
                4'h9: v = 20'd680;
                4'ha: v = 20'd360;
                4'hb: v = 20'd296;
                4'hc: v = 20'd168;
                default: v = 20'd104;
            endcase
        end
        else
        begin
            case (dr)
                4'h0: v = 20'd307265;
                4'h1: v = 20'd153665;
                4'h2: v = 20'd76865;
                4'h3: v = 20'd46145;
                4'h4: v = 20'd38465;
                4'h5: v = 20'd15425;
                4'h6: v = 20'd12857;
                4'h7: v = 20'd7745;
                4'h8: v = 20'd3905;
                4'h9: v = 20'd1985;
                4'ha: v = 20'd1025;
                4'hb: v = 20'd808;
                4'hc: v = 20'd424;
                default: v = 20'd232;
            endcase
        end
        return v;
    endfunction : adcgc_conv_len

    // Plain data period of continuous unchopped operation, in modulator periods.
    function automatic logic [ADCGC_CNT_W-1:0] adcgc_nominal_len(input logic [3:0] dr);
        logic [ADCGC_CNT_W-1:0] v;
        v = 20'h00000;
        case (dr)
            4'h0: v = 20'd102400;
            4'h1: v = 20'd51200;
            4'h2: v = 20'd25600;
            4'h3: v = 20'd15360;
            4'h4: v = 20'd12800;
            4'h5: v = 20'd5120;
            4'h6: v = 20'd4264;
            4'h7: v = 20'd2560;
            4'h8: v = 20'd1280;
            4'h9: v = 20'd640;
            4'ha: v = 20'd320;
            4'hb: v = 20'd256;
            4'hc: v = 20'd128;
            default: v = 20'd64;
        endcase
        return v;
    endfunction : adcgc_nominal_len

endpackage : adcgc_pkg

// ---- adcgc_sequencer.sv ----
// Summary of operation
// - Chop sequence runs only while the chop bit of register 04h is set.
// - Chopped pair: first conversion normal polarity, second with inputs reversed.
// - Chopped result is half the difference of normal and reversed conversions, cancelling offset.
// - Low-latency filter: first chopped result after about two conversion periods.
// - Sinc3 filter: first chopped result after about six conversion periods.
// - Continuous chopped conversions after the first take one conversion length each, without the pre-conversion delay.
// - Continuous chop pipelines polarities; each data cycle halves the difference of the two latest.
// - Sequence starts on trigger pin rising edge or the start command strobe.
// - Low-latency chop periods follow the per-rate modulator period counts.
// - Pre-conversion delay precedes both conversions of a pair, 14 periods each by default.
// - All durations count ADC clock cycles, so they scale with that clock.
// - Sinc3 suppresses its first two unsettled outputs in every mode.
`timescale 1ns/1ps
module adcgc_sequencer
    import adcgc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start_pin,
    input wire logic start_cmd,
    input wire logic adc_clk_pin,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [ADCGC_RES_W-1:0] mod_result,
    output logic polarity_swap,
    output logic conv_busy,
    output logic [ADCGC_RES_W-1:0] result_data,
    output logic result_valid,
    input wire logic result_ready
);
    // Results wait here while the host is slow to read; a full FIFO stalls the sequence.
    adcgc_stream_if #(.W(ADCGC_RES_W)) push_if ();
    adcgc_stream_if #(.W(ADCGC_RES_W)) pop_if ();

    adcgc_fifo #(.W(ADCGC_RES_W), .DEPTH(ADCGC_FIFO_DEPTH)) u_fifo (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_s(push_if.snk),
        .out_s(pop_if.src)
    );

    assign result_data = pop_if.data;
    assign result_valid = pop_if.valid;
    assign pop_if.ready = result_ready;

    // Pin inputs come from outside this clock and are synchronised first.
    logic [1:0] start_sync_q;
    logic start_old_q;
    logic [1:0] aclk_sync_q;
    logic aclk_old_q;
    logic [3:0] div_q, div_d;

    adcgc_state_t state_q, state_d;
    logic [ADCGC_CNT_W-1:0] cnt_q, cnt_d, len_q, len_d;
    logic [7:0] cfg_q, cfg_d, rdata_d;
    logic pol_q, pol_d, have_q, have_d;
    logic [ADCGC_RES_W-1:0] prev_q, prev_d;
    logic tick, trig, cfg_wr, restart, chop, single, lowlat, done, push;
    logic [ADCGC_RES_W:0] diff;
    logic [ADCGC_RES_W-1:0] push_data;
    logic [3:0] dr;

    always_comb
    begin
        cfg_wr = reg_wr_en && (reg_addr == ADCGC_DRATE_ADDR);
        cfg_d = cfg_wr ? reg_wdata : cfg_q;
        rdata_d = (reg_addr == ADCGC_DRATE_ADDR) ? cfg_q : 8'h00;
        chop = cfg_q[ADCGC_CHOP_BIT];
        single = cfg_q[ADCGC_SINGLE_BIT];
        lowlat = cfg_q[ADCGC_LOWLAT_BIT];
        dr = cfg_q[ADCGC_DR_LSB +: ADCGC_DR_W];
        // One modulator period per sixteen ADC clock rising edges.
        // The divider runs free and a trigger does not clear it, so the first delay
        // period after a trigger may be up to one modulator period short.
        tick = aclk_sync_q[1] && !aclk_old_q && (div_q == ADCGC_MOD_DIV_LAST);
        div_d = (aclk_sync_q[1] && !aclk_old_q) ? div_q + 4'h1 : div_q;
        trig = (start_sync_q[1] && !start_old_q) || start_cmd;
        restart = trig || (cfg_wr && (reg_wdata[ADCGC_CHOP_BIT] != chop)
                           && (state_q != ADCGC_IDLE));
        done = (state_q == ADCGC_CONV) && (cnt_q == len_q);
        // The reversed conversion carries the signal negated, so the offset cancels.
        if (pol_q)
        begin
            diff = {prev_q[ADCGC_RES_W-1], prev_q} - {mod_result[ADCGC_RES_W-1], mod_result};
        end
        else
        begin
            diff = {mod_result[ADCGC_RES_W-1], mod_result} - {prev_q[ADCGC_RES_W-1], prev_q};
        end
        push_data = chop ? diff[ADCGC_RES_W:1] : mod_result;
        push = done && (!chop || have_q);
        push_if.valid = push;
        push_if.data = push_data;

        state_d = state_q;
        cnt_d = cnt_q;
        len_d = len_q;
        pol_d = pol_q;
        have_d = have_q;
        prev_d = prev_q;
        if (restart)
        begin
            // The sinc3 length spans three settling conversions, so the two unsettled
            // outputs never reach the FIFO.
            state_d = ADCGC_DELAY;
            cnt_d = '0;
            pol_d = 1'b0;
            have_d = 1'b0;
            len_d = adcgc_conv_len(cfg_d[ADCGC_LOWLAT_BIT], cfg_d[ADCGC_DR_LSB +: ADCGC_DR_W]);
        end
        else
        begin
            case (state_q)
                ADCGC_DELAY:
                begin
                    if (tick)
                    begin
                        if (cnt_q == ADCGC_DELAY_MODULATOR_PERIOD - 20'h1)
                        begin
                            cnt_d = '0;
                            state_d = ADCGC_CONV;
                        end
                        else
                        begin
                            cnt_d = cnt_q + 20'h1;
                        end
                    end
                end
                ADCGC_CONV:
                begin
                    if (!done)
                    begin
                        cnt_d = tick ? cnt_q + 20'h1 : cnt_q;
                    end
                    else if (chop && !have_q)
                    begin
                        // First of the pair taken; swap inputs and settle again.
                        prev_d = mod_result;
                        have_d = 1'b1;
                        pol_d = 1'b1;
                        cnt_d = '0;
                        state_d = ADCGC_DELAY;
                    end
                    else if (push_if.ready)
                    begin
                        prev_d = mod_result;
                        cnt_d = '0;
                        if (single)
                        begin
                            state_d = ADCGC_IDLE;
                            have_d = 1'b0;
                            pol_d = 1'b0;
                        end
                        else
                        begin
                            // Later chopped results need one new conversion each.
                            pol_d = chop ? !pol_q : 1'b0;
                            if (chop)
                            begin
                                len_d = adcgc_conv_len(lowlat, dr);
                            end
                            else
                            begin
                                len_d = adcgc_nominal_len(dr);
                            end
                            state_d = ADCGC_CONV;
                        end
                    end
                end
                default:
                begin
                    cnt_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            start_sync_q <= 2'b00;
            start_old_q <= 1'b0;
            aclk_sync_q <= 2'b00;
            aclk_old_q <= 1'b0;
            div_q <= 4'h0;
            state_q <= ADCGC_IDLE;
            cnt_q <= '0;
            len_q <= '0;
            cfg_q <= ADCGC_DRATE_RESET;
            reg_rdata <= 8'h00;
            pol_q <= 1'b0;
            have_q <= 1'b0;
            prev_q <= '0;
            polarity_swap <= 1'b0;
            conv_busy <= 1'b0;
        end
        else
        begin
            start_sync_q <= {start_sync_q[0], start_pin};
            start_old_q <= start_sync_q[1];
            aclk_sync_q <= {aclk_sync_q[0], adc_clk_pin};
            aclk_old_q <= aclk_sync_q[1];
            div_q <= div_d;
            state_q <= state_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            cfg_q <= cfg_d;
            reg_rdata <= rdata_d;
            pol_q <= pol_d;
            have_q <= have_d;
            prev_q <= prev_d;
            polarity_swap <= pol_d;
            conv_busy <= (state_d != ADCGC_IDLE);
        end
    end
endmodule : adcgc_sequencer

// ---- adcgc_sequencer_props.sv ----
`timescale 1ns/1ps
module adcgc_seq_props
    import adcgc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic start_pin,
    input wire logic start_cmd,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic polarity_swap,
    input wire logic conv_busy,
    input wire logic [ADCGC_RES_W-1:0] result_data,
    input wire logic result_valid,
    input wire logic result_ready
);
    // The fastest legal ADC clock gives 64 ref_clk cycles per modulator period.
    localparam logic [15:0] MIN_FIRST = 16'd7552;
    logic [15:0] cnt_q, cnt_d;
    logic pend_q, pend_d;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    always_comb
    begin
        cnt_d = start_cmd ? 16'h0000 : cnt_q + {15'h0000, cnt_q != 16'hffff};
        pend_d = start_cmd | (pend_q & ~result_valid);
    end
    always_ff @(posedge ref_clk)
    begin
        cnt_q <= rst_n ? cnt_d : 16'h0000;
        pend_q <= rst_n & pend_d;
    end
    AST_RST_CLEAR: assert property (disable iff (1'b0)
        !rst_n |=> !conv_busy && !result_valid && !polarity_swap) else $error("reset left outputs");
    AST_START_BUSY: assert property (start_cmd |=> conv_busy)
        else $error("start did not set busy");
    AST_FIRST_NORMAL: assert property (start_cmd |=> !polarity_swap [*8])
        else $error("pair did not open normal");
    AST_SWAP_IN_SEQ: assert property ($changed(polarity_swap) |-> $past(conv_busy))
        else $error("polarity moved while idle");
    AST_BUSY_CAUSE: assert property ($rose(conv_busy) |-> $past(start_cmd) ||
        $past(start_pin, 2) || $past(start_pin, 3) || $past(start_pin, 4) || $past(start_pin, 5))
        else $error("busy without trigger");
    AST_HOLD: assert property (result_valid && !result_ready |=>
        result_valid && $stable(result_data)) else $error("result dropped");
    AST_UNMAPPED: assert property (reg_addr != ADCGC_DRATE_ADDR |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_READBACK: assert property (reg_wr_en && reg_addr == ADCGC_DRATE_ADDR ##1
        !reg_wr_en && reg_addr == ADCGC_DRATE_ADDR |=> reg_rdata == $past(reg_wdata, 2))
        else $error("readback wrong");
    AST_FIRST_MIN: assert property (pend_q && result_valid |-> cnt_q >= MIN_FIRST)
        else $error("first result too early");
endmodule : adcgc_seq_props
bind adcgc_sequencer adcgc_seq_props u_props (.ref_clk(ref_clk), .rst_n(rst_n),
    .start_pin(start_pin), .start_cmd(start_cmd), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .polarity_swap(polarity_swap),
    .conv_busy(conv_busy), .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready));

// ---- adcgc_stream_if.sv ----
`timescale 1ns/1ps
interface adcgc_stream_if #(parameter int W = 24);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : adcgc_stream_if

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    import adcgc_pkg::*;
    localparam int HALF = 2;
    localparam int MREF = 32 * HALF;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic start_pin = 1'b0;
    logic start_cmd = 1'b0;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic result_ready = 1'b0;
    logic adc_clk_pin, polarity_swap, conv_busy, result_valid;
    logic [7:0] reg_rdata;
    logic [ADCGC_RES_W-1:0] mod_result, result_data;
    logic hs = 1'b0;
    logic [ADCGC_RES_W-1:0] hd;
    logic [31:0] rs = 32'h92f17730;
    int errors = 0;
    int n_compared = 0;
    int sig = 0;
    int ofs = 0;
    int cyc;
    int exp_q[$];
    always #2.5 ref_clk = ~ref_clk;
    adcgc_sequencer uut (.ref_clk(ref_clk), .rst_n(rst_n), .start_pin(start_pin),
        .start_cmd(start_cmd), .adc_clk_pin(adc_clk_pin), .reg_wr_en(reg_wr_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .mod_result(mod_result), .polarity_swap(polarity_swap), .conv_busy(conv_busy),
        .result_data(result_data), .result_valid(result_valid), .result_ready(result_ready));
    adcgc_front_model #(.HALF(HALF)) u_front (.ref_clk(ref_clk), .polarity_swap(polarity_swap),
        .sig(sig[23:0]), .ofs(ofs[23:0]), .adc_clk_pin(adc_clk_pin), .mod_result(mod_result));
    function automatic logic [31:0] xs();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : xs
    always @(posedge ref_clk)
    begin
        hs <= result_valid & result_ready;
        hd <= result_data;
        result_ready <= #1 (xs() % 32'd4) != 0;
    end
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        if (errors == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        step();
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step();
        reg_wr_en = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        step();
        reg_addr = a;
        step();
        chk("reg_rdata", {24'h000000, reg_rdata}, {24'h000000, e});
    endtask : rd
    // A pin trigger is held a few cycles so the synchroniser cannot miss it.
    task automatic kick(input logic cmd);
        sig = int'(xs() % 32'd1000000) - 500000;
        ofs = int'(xs() % 32'd60000) - 30000;
        step();
        start_cmd = cmd;
        start_pin = ~cmd;
        step();
        start_cmd = 1'b0;
        repeat (3) step();
        start_pin = 1'b0;
        chk("conv_busy", {31'h0, conv_busy}, 32'h1);
        chk("polarity_swap", {31'h0, polarity_swap}, 32'h0);
    endtask : kick
    task automatic get_res(input int m, input string nm, input logic ch);
        exp_q.push_back(ch ? ((ofs + sig) - (ofs - sig)) >>> 1 : ofs + sig);
        cyc = 0;
        do
        begin
            step();
            cyc++;
        end
        while (hs !== 1'b1 && cyc < 40000);
        chk(nm, 32'(cyc > m * MREF - 80 && cyc < m * MREF + 80), 32'h1);
        chk(nm, {8'h00, hd}, 32'(exp_q.pop_front()) & 32'h00ffffff);
    endtask : get_res
    initial
    begin
        #490000;
        errors++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        rd(8'h04, ADCGC_DRATE_RESET);
        wr(8'h05, 8'h33);
        rd(8'h05, 8'h00);
        rd(8'h04, ADCGC_DRATE_RESET);
        wr(8'h04, 8'h9d);
        rd(8'h04, 8'h9d);
        kick(1'b1);
        get_res(236, "chop_first", 1'b1);
        chk("polarity_swap", {31'h0, polarity_swap}, 32'h0);
        get_res(104, "chop_next", 1'b1);
        chk("polarity_swap", {31'h0, polarity_swap}, 32'h1);
        get_res(104, "chop_next", 1'b1);
        chk("polarity_swap", {31'h0, polarity_swap}, 32'h0);
        repeat (3000) step();
        kick(1'b1);
        get_res(236, "restart", 1'b1);
        wr(8'h04, 8'h1d);
        kick(1'b0);
        get_res(118, "plain", 1'b0);
        get_res(64, "plain_next", 1'b0);
        wr(8'h04, 8'had);
        kick(1'b1);
        get_res(492, "sinc_chop", 1'b1);
        chk("conv_busy", {31'h0, conv_busy}, 32'h0);
        print_verdict();
    end
endmodule : tb
